//--- core/mbc_pkg.sv
package mbc_pkg;

    // Clock rate.
    localparam int CLK_MHZ = 100;

    // Times in their own units and derived cycle counts.
    localparam int BLANK_NS        = 3000;
    localparam int BLANK_CYC       = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int OFF_TIME_NS     = 25000;
    localparam int OFF_TIME_CYC    = (OFF_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int FAST_PART_CYC   = OFF_TIME_CYC / 2;
    localparam int DEAD_NS         = 400;
    localparam int DEAD_CYC        = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int STANDBY_US      = 1000;
    localparam int STANDBY_CYC     = STANDBY_US * CLK_MHZ;
    localparam int RETRY_US        = 2000;
    localparam int RETRY_CYC       = RETRY_US * CLK_MHZ;
    localparam int TIMER_W         = 24;

    // Reset values.
    localparam logic RST_FAULT_N   = 1'h1;

    // Bridge states.
    typedef enum logic [6:0] {
        ST_OFF   = 7'h01,
        ST_DRIVE = 7'h02,
        ST_FAST  = 7'h04,
        ST_DEAD  = 7'h08,
        ST_SLOW  = 7'h10,
        ST_BRAKE = 7'h20,
        ST_COAST = 7'h40
    } mbc_state_type;

    // One half-bridge: high side on, low side on.
    typedef struct packed {
        logic hiOn;
        logic loOn;
    } mbc_leg_type;

    // Protection flags from the analog front end.
    typedef struct packed {
        logic overcurrent;
        logic thermal;
        logic lowSupply;
    } mbc_prot_type;

endpackage : mbc_pkg

//--- core/mbc_timer.sv
`timescale 1ns/10ps
// Down counter: load starts it, done pulses one cycle when it reaches zero.
module mbc_timer
    import mbc_pkg::*;
#(
    parameter int W = TIMER_W
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Control.
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    input  wire logic         stop,
    // Status.
    output logic              busy,
    output logic              done
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         busy_r;
    logic         busy_nxt;
    logic         done_r;
    logic         done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (stop) begin
            busy_nxt = 1'b0;
        end else if (load) begin
            cnt_nxt  = count;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r <= W'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;

endmodule : mbc_timer

//--- core/mbc_bridge_ctrl.sv
`timescale 1ns/10ps
// What this block does
// R1: 1,0 drives forward; 0,1 drives reverse.
// R2: Forward trip: a low, b toggles.
// R3: Reverse trip: b low, a toggles.
// R4: Both high brakes both low while held.
// R5: Both low leaves outputs floating.
// R6: Low inputs over 1 ms enter standby.
// R7: Controller waits 200 us after standby exit. The code adds no wait; the bridge follows the inputs once standby clears.
// R8: Drive latch set per on-period, trip clears.
// R9: Decay holds fixed off-time, then redrive.
// R10: Comparator ignored 3 us after turn-on.
// R11: Overcurrent pulls fault output low.
// R12: Retry grounded: re-enable after 2 ms.
// R13: Retry open: fault latches, outputs off.
// R14: Latched fault cleared only leaving standby. The no-retry variant also clears it on entering standby.
// R15: No-retry variant always latches faults.
// R16: Thermal flag disables bridge until cleared.
// R17: Low supply holds all drivers off.
// R18: Off-time: half fast, dead time, slow.
module mbc_bridge_ctrl
    import mbc_pkg::*;
#(
    parameter bit          HAS_RETRY   = 1'b1,
    parameter int unsigned STANDBY_CNT = STANDBY_CYC,
    parameter int unsigned RETRY_CNT   = RETRY_CYC
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Controller inputs.
    input  wire logic         dir_select_a,
    input  wire logic         dir_select_b,
    input  wire logic         retry_select,
    // Analog front end.
    input  wire logic         current_trip,
    input  wire mbc_prot_type prot,
    // Bridge legs; an off leg is high impedance.
    output mbc_leg_type       bridge_out_a,
    output mbc_leg_type       bridge_out_b,
    // Open-drain fault pin and status.
    output logic              fault_out_n_o,
    output logic              fault_out_n_oe,
    output logic              standby
);

    ////////////////////////////////////////////////////////////////////////////
    // Timers.

    logic                 offLoad;
    logic                 offStop;
    logic [TIMER_W-1:0]   offCount;
    logic                 offBusy;
    logic                 offDone;
    logic                 blankLoad;
    logic                 blankBusy;
    logic                 retryLoad;
    logic                 retryBusy;
    logic                 retryDone;

    mbc_timer #(.W(TIMER_W)) offTimer (
        .clk   (clk),
        .rst   (rst),
        .load  (offLoad),
        .count (offCount),
        .stop  (offStop),
        .busy  (offBusy),
        .done  (offDone)
    );

    mbc_timer #(.W(TIMER_W)) blankTimer (
        .clk   (clk),
        .rst   (rst),
        .load  (blankLoad),
        .count (TIMER_W'(BLANK_CYC)),
        .stop  (1'b0),
        .busy  (blankBusy),
        .done  ()
    );

    mbc_timer #(.W(TIMER_W)) retryTimer (
        .clk   (clk),
        .rst   (rst),
        .load  (retryLoad),
        .count (TIMER_W'(RETRY_CNT)),
        .stop  (1'b0),
        .busy  (retryBusy),
        .done  (retryDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Standby timer and fault latch.

    logic [TIMER_W-1:0] idleCnt_r;
    logic [TIMER_W-1:0] idleCnt_nxt;
    logic               standby_r;
    logic               standby_nxt;
    logic               fault_r;
    logic               fault_nxt;
    logic               bothLow;
    logic               latchMode;

    assign bothLow   = !dir_select_a && !dir_select_b;
    // An open retry pin reads high; the variant without it always latches.
    assign latchMode = !HAS_RETRY || retry_select;  // see R13, R15

    always_comb begin
        idleCnt_nxt = idleCnt_r;
        standby_nxt = standby_r;
        fault_nxt   = fault_r;
        retryLoad   = 1'b0;
        if (!bothLow) begin
            idleCnt_nxt = '0;  // see R6
            standby_nxt = 1'b0;
            if (standby_r) begin
                fault_nxt = 1'b0;  // see R14
            end
        end else if (idleCnt_r < TIMER_W'(STANDBY_CNT)) begin
            idleCnt_nxt = idleCnt_r + TIMER_W'(1);
        end else begin
            standby_nxt = 1'b1;  // see R6
            if (!HAS_RETRY) begin
                fault_nxt = 1'b0;  // see R15
            end
        end
        if (!latchMode && retryDone) begin
            fault_nxt = 1'b0;  // see R12
        end
        // A new overcurrent outside standby wins over any clear in the same cycle.
        if (prot.overcurrent && !standby_r) begin
            fault_nxt = 1'b1;  // see R11
            // A fault still present when the retry expires must start a new wait.
            if (!latchMode && (!fault_r || retryDone)) begin
                retryLoad = 1'b1;  // see R12
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            idleCnt_r <= '0;
            standby_r <= 1'b0;
            fault_r   <= 1'b0;
        end else begin
            idleCnt_r <= idleCnt_nxt;
            standby_r <= standby_nxt;
            fault_r   <= fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bridge state machine.

    mbc_state_type state_r;
    mbc_state_type state_nxt;
    mbc_leg_type   legA_r;
    mbc_leg_type   legA_nxt;
    mbc_leg_type   legB_r;
    mbc_leg_type   legB_nxt;
    logic          fltOe_r;
    logic          fltOe_nxt;
    logic          fwd;
    logic          rev;
    logic          inhibit;
    logic          armed;

    assign fwd     = dir_select_a && !dir_select_b;
    assign rev     = !dir_select_a && dir_select_b;
    // Thermal and supply flags are hysteretic upstream; we follow them level by level.
    // The next fault value is used so that the bridge is off one cycle after an overcurrent.
    assign inhibit = prot.lowSupply || prot.thermal || fault_nxt || standby_r;  // see R11, R16, R17
    assign armed   = !blankBusy;  // see R10

    always_comb begin
        state_nxt = state_r;
        offLoad   = 1'b0;
        offCount  = TIMER_W'(FAST_PART_CYC);
        blankLoad = 1'b0;
        case (state_r)
            ST_OFF, ST_COAST, ST_BRAKE: begin
                if (fwd || rev) begin
                    state_nxt = ST_DRIVE;  // see R8
                    blankLoad = 1'b1;
                end else if (dir_select_a && dir_select_b) begin
                    state_nxt = ST_BRAKE;  // see R4
                end else begin
                    state_nxt = ST_COAST;  // see R5
                end
            end
            ST_DRIVE: begin
                if (!(fwd || rev)) begin
                    state_nxt = ST_OFF;
                end else if (fwd != legA_r.hiOn) begin
                    // A reversal turns on the other diagonal, so it is blanked like a fresh start.
                    blankLoad = 1'b1;  // see R10
                end else if (current_trip && armed) begin
                    state_nxt = ST_FAST;  // see R8, R2, R3
                    offLoad   = 1'b1;
                    offCount  = TIMER_W'(FAST_PART_CYC);  // see R18
                end
            end
            ST_FAST: begin
                // Brake or coast on the selectors ends a chop at once.
                if (!(fwd || rev)) begin
                    state_nxt = ST_OFF;  // see R4, R5
                end else if (offDone) begin
                    state_nxt = ST_DEAD;  // see R18
                    offLoad   = 1'b1;
                    offCount  = TIMER_W'(DEAD_CYC);
                end
            end
            ST_DEAD: begin
                if (!(fwd || rev)) begin
                    state_nxt = ST_OFF;  // see R4, R5
                end else if (offDone) begin
                    state_nxt = ST_SLOW;
                    offLoad   = 1'b1;
                    offCount  = TIMER_W'(OFF_TIME_CYC - FAST_PART_CYC - DEAD_CYC);
                end
            end
            ST_SLOW: begin
                if (!(fwd || rev)) begin
                    state_nxt = ST_OFF;  // see R4, R5
                end else if (offDone) begin
                    state_nxt = ST_OFF;  // see R9
                end
            end
            default: state_nxt = ST_OFF;
        endcase
        if (inhibit) begin
            state_nxt = ST_OFF;  // see R17
        end
        // A chop cut short must not leave a stale done pulse for the next one.
        offStop = (state_nxt != ST_FAST) && (state_nxt != ST_DEAD) && (state_nxt != ST_SLOW);
    end

    // Output legs per state; off leg means floating.
    always_comb begin
        legA_nxt = '0;
        legB_nxt = '0;
        case (state_nxt)
            ST_DRIVE: begin
                legA_nxt = fwd ? 2'h2 : 2'h1;  // see R1
                legB_nxt = fwd ? 2'h1 : 2'h2;
            end
            ST_FAST: begin
                // Drive opposite diagonal: current falls quickly.
                legA_nxt = fwd ? 2'h1 : 2'h2;  // see R2, R3
                legB_nxt = fwd ? 2'h2 : 2'h1;
            end
            ST_SLOW, ST_BRAKE: begin
                legA_nxt = 2'h1;  // see R4
                legB_nxt = 2'h1;
            end
            default: begin
                legA_nxt = '0;  // see R5
                legB_nxt = '0;
            end
        endcase
        fltOe_nxt = fault_nxt;  // see R11
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_OFF;
            legA_r  <= '0;
            legB_r  <= '0;
            fltOe_r <= !RST_FAULT_N;
        end else begin
            state_r <= state_nxt;
            legA_r  <= legA_nxt;
            legB_r  <= legB_nxt;
            fltOe_r <= fltOe_nxt;
        end
    end

    assign bridge_out_a   = legA_r;
    assign bridge_out_b   = legB_r;
    assign fault_out_n_o  = 1'b0;
    assign fault_out_n_oe = fltOe_r;
    assign standby        = standby_r;

    logic unusedBusy;
    assign unusedBusy = offBusy ^ retryBusy;

endmodule : mbc_bridge_ctrl

//--- dv/mbc_bridge_chk.sv
`timescale 1ns/10ps
module mbc_bridge_chk
    import mbc_pkg::*;
#(
    parameter int unsigned STANDBY_CNT = STANDBY_CYC
) (
    // Clock and reset.
    input wire logic         clk,
    input wire logic         rst,
    // Inputs.
    input wire logic         dir_select_a,
    input wire logic         dir_select_b,
    input wire logic         retry_select,
    input wire logic         current_trip,
    input wire mbc_prot_type prot,
    // Outputs.
    input wire mbc_leg_type  bridge_out_a,
    input wire mbc_leg_type  bridge_out_b,
    input wire logic         fault_out_n_o,
    input wire logic         fault_out_n_oe,
    input wire logic         standby
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [23:0] lowCnt_r;
    logic [23:0] lowCnt_nxt;
    logic        idle;
    logic        quiet;
    assign idle  = !dir_select_a && !dir_select_b;
    assign quiet = prot == 3'h0 && !fault_out_n_oe && !standby;
    always_comb begin
        lowCnt_nxt = idle ? lowCnt_r + 24'h1 : 24'h0;
    end
    always_ff @(posedge clk) begin
        lowCnt_r <= rst ? 24'h0 : lowCnt_nxt;
    end
    ////////////////////////////////////////
    sequence s_brake_held;
        (dir_select_a && dir_select_b && quiet) [*2];
    endsequence
    a_coast_float: assert property (idle |=> {bridge_out_a, bridge_out_b} == 4'h0)
        else $error("coast legs not floating");
    a_brake_low: assert property (s_brake_held |=> {bridge_out_a, bridge_out_b} == 4'h5)
        else $error("brake legs wrong");
    a_supply_off: assert property (prot.lowSupply |=> {bridge_out_a, bridge_out_b} == 4'h0)
        else $error("drive during low supply");
    a_hot_off: assert property (prot.thermal |=> {bridge_out_a, bridge_out_b} == 4'h0)
        else $error("drive during thermal flag");
    a_ocp_flag: assert property (prot.overcurrent && !standby
        |=> fault_out_n_oe && {bridge_out_a, bridge_out_b} == 4'h0)
        else $error("overcurrent not flagged");
    a_od_low: assert property (fault_out_n_o == 1'b0)
        else $error("fault pin data not low");
    a_fault_latch: assert property (fault_out_n_oe && retry_select && !standby |=> fault_out_n_oe)
        else $error("latched fault dropped");
    a_no_shoot: assert property (!(bridge_out_a.hiOn && bridge_out_a.loOn)
        && !(bridge_out_b.hiOn && bridge_out_b.loOn))
        else $error("leg shoot-through");
    a_standby_in: assert property (lowCnt_r == STANDBY_CNT + 3 |-> standby)
        else $error("standby not entered");
    a_standby_early: assert property (lowCnt_r > 24'h2 && lowCnt_r < STANDBY_CNT - 2 |-> !standby)
        else $error("standby too early");
    a_wake_up: assert property (standby && !idle |-> ##[1:2] !standby)
        else $error("standby not left");
endmodule : mbc_bridge_chk

bind mbc_bridge_ctrl mbc_bridge_chk #(.STANDBY_CNT(STANDBY_CNT)) u_chk (
    .clk(clk), .rst(rst), .dir_select_a(dir_select_a), .dir_select_b(dir_select_b),
    .retry_select(retry_select), .current_trip(current_trip), .prot(prot),
    .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b), .fault_out_n_o(fault_out_n_o),
    .fault_out_n_oe(fault_out_n_oe), .standby(standby));

//--- dv/mbc_motor_model.sv
`timescale 1ns/10ps
module mbc_motor_model
    import mbc_pkg::*;
#(
    parameter int TRIP = 200
) (
    // Clock.
    input wire logic        clk,
    // Bridge legs.
    input wire mbc_leg_type legA,
    input wire mbc_leg_type legB,
    // Comparator.
    output logic            trip
);
    int cur = 0;
    int dir;
    // Decay stops at zero; rectification never reverses the winding current.
    always @(posedge clk) begin
        dir = ({legA, legB} == 4'h9) ? 1 : ({legA, legB} == 4'h6) ? -1 : 0;
        if (dir != 0 && (cur == 0 || (cur > 0) == (dir > 0))) begin
            cur <= cur + dir;
        end else begin
            cur <= cur > 0 ? cur - 1 : cur < 0 ? cur + 1 : 0;
        end
    end
    assign trip = cur >= TRIP || cur <= -TRIP;
endmodule : mbc_motor_model

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import mbc_pkg::*;
();
    localparam int SB = 50;
    localparam int RT = 100;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         dirA = 1'b0;
    logic         dirB = 1'b0;
    logic         retry = 1'b0;
    logic         trip;
    mbc_prot_type prot = '0;
    mbc_leg_type  outA;
    mbc_leg_type  outB;
    logic         faultOe;
    logic         faultOe2;
    logic         standby;
    int           n_mismatch = 0;
    int           n_tests = 0;
    always #5 clk = ~clk;
    mbc_bridge_ctrl #(.HAS_RETRY(1'b1), .STANDBY_CNT(SB), .RETRY_CNT(RT)) dut (
        .clk(clk), .rst(rst), .dir_select_a(dirA), .dir_select_b(dirB), .retry_select(retry),
        .current_trip(trip), .prot(prot), .bridge_out_a(outA), .bridge_out_b(outB),
        .fault_out_n_o(), .fault_out_n_oe(faultOe), .standby(standby));
    // Variant without the retry pin; it always latches.
    mbc_bridge_ctrl #(.HAS_RETRY(1'b0), .STANDBY_CNT(SB), .RETRY_CNT(RT)) dutNoRetry (
        .clk(clk), .rst(rst), .dir_select_a(dirA), .dir_select_b(dirB), .retry_select(1'b0),
        .current_trip(trip), .prot(prot), .bridge_out_a(), .bridge_out_b(),
        .fault_out_n_o(), .fault_out_n_oe(faultOe2), .standby());
    mbc_motor_model motor (.clk(clk), .legA(outA), .legB(outB), .trip(trip));
    ////////////////////////////////////////
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic near(string what, int exp, int got, int tol);
        n_tests++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : near
    task automatic drive(logic [1:0] d, int n);
        @(negedge clk);
        {dirA, dirB} = d;
        repeat (n) @(negedge clk);
    endtask : drive
    task automatic waitLegs(logic [3:0] want, int lim, output int n);
        n = 0;
        while ({outA, outB} !== want) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                n_mismatch++;
                $display("[ERR] legs expected %h seen %h", want, {outA, outB});
                results();
            end
        end
    endtask : waitLegs
    function automatic logic [3:0] expLegs(logic [1:0] d, mbc_prot_type p);
        if (p.thermal || p.lowSupply) begin
            return 4'h0;
        end
        case (d)
            2'b10: return 4'h9;
            2'b01: return 4'h6;
            2'b11: return 4'h5;
            default: return 4'h0;
        endcase
    endfunction : expLegs
    ////////////////////////////////////////
    initial begin
        int n1;
        int n2;
        int n3;
        logic [1:0] d;
        void'($urandom(32'h9aa6));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("reset legs", 4'h0, {outA, outB});
        chk("reset fault", 4'h0, {3'h0, faultOe});
        for (int i = 0; i < 2; i++) begin
            d = i ? 2'b01 : 2'b10;
            drive(d, 250);
            chk("blanked drive", expLegs(d, '0), {outA, outB});
            waitLegs(expLegs(~d, '0), 200, n1);
            waitLegs(4'h0, 2000, n1);
            waitLegs(4'h5, 200, n2);
            waitLegs(expLegs(d, '0), 2000, n3);
            near("fast part", FAST_PART_CYC, n1, 3);
            near("dead time", DEAD_CYC, n2, 3);
            near("off time", OFF_TIME_CYC, n1 + n2 + n3, 5);
        end
        drive(2'b11, 20);
        chk("brake", 4'h5, {outA, outB});
        drive(2'b00, SB - 5);
        chk("coast", 4'h0, {outA, outB});
        chk("no standby", 4'h0, {3'h0, standby});
        repeat (10) @(negedge clk);
        chk("standby", 4'h1, {3'h0, standby});
        // The test holds brake for 20000 cycles (200 us); the controller itself adds no settling wait.
        drive(2'b11, 20000);
        chk("awake", 4'h0, {3'h0, standby});
        for (int k = 0; k < 40; k++) begin
            d = 2'($urandom());
            prot = mbc_prot_type'(3'($urandom()) & 3'($urandom()) & 3'h3);
            drive(d, 3);
            chk("random legs", expLegs(d, prot), {outA, outB});
        end
        prot = '0;
        for (int r = 0; r < 2; r++) begin
            retry = r[0];
            drive(2'b11, 2);
            prot.overcurrent = 1'b1;
            @(negedge clk);
            prot.overcurrent = 1'b0;
            chk("fault pin", 4'h1, {3'h0, faultOe});
            chk("fault legs", 4'h0, {outA, outB});
            repeat (RT + 10) @(negedge clk);
            chk("retry fault", r ? 4'h1 : 4'h0, {3'h0, faultOe});
            chk("no-retry fault", 4'h1, {3'h0, faultOe2});
            chk("retry legs", r ? 4'h0 : 4'h5, {outA, outB});
        end
        drive(2'b10, 5);
        chk("latched legs", 4'h0, {outA, outB});
        drive(2'b00, SB + 10);
        chk("latched in standby", 4'h1, {3'h0, faultOe});
        chk("no-retry standby", 4'h0, {3'h0, faultOe2});
        drive(2'b11, 3);
        chk("cleared fault", 4'h0, {3'h0, faultOe});
        chk("cleared legs", 4'h5, {outA, outB});
        results();
    end
endmodule : tb_top
